/* File: rtl/mnco_main_ctrl.sv */
// paged control, tuning word load and acknowledge logic for the main oscillators
`timescale 1ns/10ps
`default_nettype none
module mnco_main_ctrl
  import mnco_pkg::*;
#(
  parameter int NUM_PATHS = 2  // main output paths
) (
  input  wire logic                              ref_clk,       // 50 MHz clock
  input  wire logic                              rst,           // async, active high
  input  wire mnco_bus_t                         busReq,        // register access
  input  wire logic                              sysrefPin,     // external sync reference
  output logic      [DATA_W-1:0]                 rdData,        // read data
  output logic                                   rdValid,       // read data strobe
  output mnco_cfg_t [NUM_PATHS-1:0]              pathCfg,       // per-path configuration
  output logic      [NUM_PATHS-1:0][WORD_W-1:0]  activeWord,    // word in use by oscillator
  output logic      [NUM_PATHS-1:0]              loadStrobe,    // word and cal tone load pulse
  output logic      [NUM_PATHS-1:0]              ncoResetPulse  // oscillator reset on sync
);

  // ==========================================================================
  // storage
  logic      [1:0]        pageFF;                   // output_path_page_select
  mnco_cfg_t              cfgFF      [NUM_PATHS];   // datapath config per path
  logic      [2:0]        modeFF     [NUM_PATHS];   // auto_request_source
  logic                   onSyncFF   [NUM_PATHS];   // tuning_load_on_sync
  logic                   reqFF      [NUM_PATHS];   // tuning_load_request
  logic                   ackFF      [NUM_PATHS];   // tuning_load_ack
  logic                   autoReqFF  [NUM_PATHS];   // automatic request, one cycle late
  logic      [WORD_W-1:0] pendingFF  [NUM_PATHS];   // main_tuning_word as written
  logic      [NUM_PATHS-1:0] loadNow;               // load event this cycle
  logic      [NUM_PATHS-1:0] swRise;                // software rising edge of request
  logic      [NUM_PATHS-1:0] syncLoad;              // sync-triggered load
  logic      [DATA_W-1:0] nxt_rdData;               // read mux result
  logic                   sysMetaFF;                // sync stage one
  logic                   sysSyncFF;                // sync stage two
  logic                   sysDlyFF;                 // for edge detection
  logic                   sysEdge;                  // reference rising edge
  logic      [11:0]       wordOff;                  // offset into word bytes
  logic                   wordHit;                  // access falls on a word byte

  assign wordOff = busReq.addr - ADDR_WORD0;
  assign wordHit = (busReq.addr >= ADDR_WORD0) && (busReq.addr <= ADDR_WORD5);
  assign sysEdge = sysSyncFF & ~sysDlyFF;

  // ==========================================================================
  // reference synchroniser; the pin is asynchronous to ref_clk
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sysMetaFF <= 1'b0;
      sysSyncFF <= 1'b0;
      sysDlyFF  <= 1'b0;
    end else begin
      sysMetaFF <= sysrefPin;
      sysSyncFF <= sysMetaFF;
      sysDlyFF  <= sysSyncFF;
    end
  end

  // ==========================================================================
  // page select; one bit per path, writes reach every selected path
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pageFF <= PAGE_RST;
    end else if (busReq.wr && busReq.addr == ADDR_PAGE) begin
      pageFF <= busReq.wdata[1:0];
    end
  end

  // ==========================================================================
  // per-path registers and load logic
  for (genvar p = 0; p < NUM_PATHS; p++) begin : g_path
    logic sel;     // this path is paged in
    logic cfgWr;   // config write to this path
    logic updWr;   // update register write to this path
    logic autoHit; // byte write matching the auto source
    assign sel     = pageFF[p];
    assign cfgWr   = busReq.wr && sel && busReq.addr == ADDR_CFG;
    assign updWr   = busReq.wr && sel && busReq.addr == ADDR_UPD;
    // codes 1..6 map to bytes 0..5; code 0 and 7 never match a byte
    assign autoHit = busReq.wr && sel && wordHit && modeFF[p] != MODE_OFF &&
                     modeFF[p] == 3'(wordOff[2:0] + MODE_STEP);  // see [R08] see [R09]
    assign swRise[p]   = updWr && busReq.wdata[UPD_REQ_BIT] && !reqFF[p];  // see [R10]
    assign syncLoad[p] = sysEdge && onSyncFF[p];                           // see [R12]
    // an automatic request takes exactly the software path
    assign loadNow[p]  = swRise[p] || autoReqFF[p] || syncLoad[p];         // see [R14]

    // configuration bits, each path stored on its own
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        cfgFF[p] <= CFG_RST;
      end else if (cfgWr) begin
        cfgFF[p] <= mnco_cfg_t'(busReq.wdata[3:0]);  // see [R01] see [R04] see [R05] see [R06] see [R07]
      end
    end

    // update register writable fields; reserved bits are not stored
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        modeFF[p]   <= MODE_OFF;
        onSyncFF[p] <= 1'b0;
        reqFF[p]    <= 1'b0;
      end else if (updWr) begin
        modeFF[p]   <= busReq.wdata[UPD_MODE_MSB:UPD_MODE_LSB];  // see [R08] see [R15]
        onSyncFF[p] <= busReq.wdata[UPD_SYNC_BIT];
        reqFF[p]    <= busReq.wdata[UPD_REQ_BIT];
      end
    end

    // pending word bytes; the request fires the cycle after the byte lands
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        pendingFF[p] <= '0;
        autoReqFF[p] <= 1'b0;
      end else begin
        if (busReq.wr && sel && wordHit) begin
          pendingFF[p][{wordOff[2:0], 3'h0} +: DATA_W] <= busReq.wdata;  // see [R13]
        end
        autoReqFF[p] <= autoHit;  // see [R09]
      end
    end

    // acknowledge: a load in the same cycle as a clear wins
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        ackFF[p] <= 1'b0;
      end else if (loadNow[p]) begin
        ackFF[p] <= 1'b1;  // see [R11]
      end else if (updWr && !busReq.wdata[UPD_REQ_BIT]) begin
        ackFF[p] <= 1'b0;  // see [R11]
      end
    end

    // active word and pulses towards the oscillator and cal tone
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        activeWord[p]    <= '0;
        loadStrobe[p]    <= 1'b0;
        ncoResetPulse[p] <= 1'b0;
      end else begin
        if (loadNow[p]) begin
          activeWord[p] <= pendingFF[p];  // see [R10]
        end
        loadStrobe[p]    <= loadNow[p];   // see [R10]
        ncoResetPulse[p] <= syncLoad[p];  // see [R12]
      end
    end

    // config straight to the datapath from a flop
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        pathCfg[p] <= CFG_RST;
      end else begin
        pathCfg[p] <= cfgWr ? mnco_cfg_t'(busReq.wdata[3:0]) : cfgFF[p];
      end
    end
  end

  // ==========================================================================
  // read mux; with several paths paged in, the lowest one answers
  always_comb begin
    int rp;
    rp = 0;
    for (int i = NUM_PATHS - 1; i >= 0; i--) begin
      if (pageFF[i]) begin
        rp = i;
      end
    end
    nxt_rdData = '0;
    if (busReq.addr == ADDR_PAGE) begin
      nxt_rdData = {6'h00, pageFF};
    end else if (busReq.addr == ADDR_CFG) begin
      nxt_rdData = {4'h0, cfgFF[rp]};
    end else if (busReq.addr == ADDR_UPD) begin
      nxt_rdData = {1'b0, modeFF[rp], 1'b0, onSyncFF[rp], ackFF[rp], reqFF[rp]};  // see [R15]
    end else if (wordHit) begin
      nxt_rdData = pendingFF[rp][{wordOff[2:0], 3'h0} +: DATA_W];
    end
  end

  // read data registered; valid the cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdData  <= '0;
      rdValid <= 1'b0;
    end else begin
      rdValid <= busReq.rd;
      if (busReq.rd) begin
        rdData <= nxt_rdData;
      end
    end
  end

  // ==========================================================================
  // checks on path 0
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic upd0Rd;  // last read hit the update register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      upd0Rd <= 1'b0;
    end else begin
      upd0Rd <= busReq.rd && busReq.addr == ADDR_UPD;
    end
  end

  sequence s_auto_hit;
    g_path[0].autoHit;
  endsequence
  sequence s_auto_done;
    autoReqFF[0] ##1 (ackFF[0] && loadStrobe[0] && activeWord[0] == pendingFF[0]);
  endsequence
  // a word byte written with the automatic source off, and no other load cause next cycle
  sequence s_off_write;
    (busReq.wr && pageFF[0] && wordHit && modeFF[0] == MODE_OFF) ##1 (!swRise[0] && !syncLoad[0]);
  endsequence

  a_mode_off_quiet: assert property (s_off_write |=> !loadStrobe[0])  // see [R08]
    else $error("load with automatic source off");

  a_cfg_write_store: assert property (g_path[0].cfgWr |=> cfgFF[0] == $past(busReq.wdata[3:0]) && pathCfg[0] == $past(busReq.wdata[3:0]))  // see [R01]
    else $error("path 0 config not stored");
  a_page_isolates_path: assert property ((busReq.wr && !pageFF[0]) |=> $stable(cfgFF[0]) && $stable(modeFF[0]))  // see [R07]
    else $error("unselected path changed");
  a_sw_load_ack: assert property (swRise[0] |=> ackFF[0] && loadStrobe[0] && activeWord[0] == $past(pendingFF[0]))  // see [R10]
    else $error("software request did not load");
  a_ack_clear_low: assert property ((g_path[0].updWr && !busReq.wdata[UPD_REQ_BIT] && !loadNow[0]) |=> !ackFF[0])  // see [R11]
    else $error("ack not cleared");
  a_auto_req_load: assert property (s_auto_hit |=> s_auto_done)  // see [R14]
    else $error("automatic request did not load");
  a_load_has_cause: assert property (loadNow[0] |-> (swRise[0] || $past(g_path[0].autoHit) || syncLoad[0]))  // see [R08]
    else $error("load without a cause");
  a_auto_byte_match: assert property (g_path[0].autoHit |-> 3'(wordOff[2:0] + MODE_STEP) == modeFF[0] && modeFF[0] != MODE_OFF)  // see [R09]
    else $error("automatic request on wrong byte");
  a_sync_load_reset: assert property ((sysEdge && onSyncFF[0]) |=> ncoResetPulse[0] && ackFF[0])  // see [R12]
    else $error("sync edge did not load");
  a_reserved_read_zero: assert property (upd0Rd |-> rdValid && !rdData[7] && !rdData[3])  // see [R15]
    else $error("reserved update bits not zero");
  a_word_byte_write: assert property ((busReq.wr && pageFF[0] && busReq.addr == ADDR_WORD5) |=> pendingFF[0][47:40] == $past(busReq.wdata))  // see [R13]
    else $error("top word byte not stored");

endmodule // mnco_main_ctrl
`default_nettype wire

/* File: rtl/mnco_pkg.sv */
// constants, field layouts and carrier types for the main oscillator control block
// ============================================================================
// Operation
// [R01] cfg bit 3 enables main oscillator
// [R02] software enables oscillator in complex modes
// [R03] no shift wanted: keep enabled, word zero
// [R04] cfg bit 2 selects fractional accumulation
// [R05] cfg bit 1 picks lower sideband
// [R06] cfg bit 0: channels follow main requests
// [R07] fields kept per path, page selects
// [R08] auto source zero: no automatic requests
// [R09] codes 1..6 request after byte write
// [R10] request rising edge loads tuning word
// [R11] ack set on load, cleared by low
// [R12] sync option loads on reference edge
// [R13] tuning word is six bytes, 48 bits
// [R14] automatic request behaves like software request
// [R15] update bits 7 and 3 read zero
package mnco_pkg;

  // ==========================================================================
  // register bus geometry
  localparam int          ADDR_W         = 12;       // register address width
  localparam int          DATA_W         = 8;        // register data width
  localparam int          WORD_W         = 48;       // tuning word width
  localparam int          WORD_BYTES     = 6;        // bytes in the tuning word

  // ==========================================================================
  // register offsets
  localparam logic [11:0] ADDR_PAGE      = 12'h008;  // output path page select
  localparam logic [11:0] ADDR_CFG       = 12'h112;  // main_nco_datapath_config
  localparam logic [11:0] ADDR_UPD       = 12'h113;  // nco_update_control
  localparam logic [11:0] ADDR_WORD0     = 12'h114;  // tuning word bits 7:0
  localparam logic [11:0] ADDR_WORD5     = 12'h119;  // tuning word bits 47:40

  // ==========================================================================
  // field positions
  localparam int          UPD_REQ_BIT    = 0;        // tuning_load_request
  localparam int          UPD_ACK_BIT    = 1;        // tuning_load_ack
  localparam int          UPD_SYNC_BIT   = 2;        // tuning_load_on_sync
  localparam int          UPD_MODE_LSB   = 4;        // auto_request_source low bit
  localparam int          UPD_MODE_MSB   = 6;        // auto_request_source high bit

  // ==========================================================================
  // reset values and codes
  localparam logic [2:0]  MODE_OFF       = 3'h0;     // no automatic requests
  localparam logic [2:0]  MODE_STEP      = 3'h1;     // code of byte 0
  localparam logic [1:0]  PAGE_RST       = 2'h3;     // both paths selected

  // per-path datapath configuration, bit order matches the register
  typedef struct packed {
    logic enable;    // main_osc_enable
    logic frac;      // fractional_accum_enable
    logic sideband;  // sideband_select
    logic follow;    // channel_osc_follow_main
  } mnco_cfg_t;

  localparam mnco_cfg_t   CFG_RST        = '{enable: 1'b0, frac: 1'b0, sideband: 1'b0, follow: 1'b1};

  // one register access, issued for a single cycle
  typedef struct packed {
    logic              wr;     // write strobe
    logic              rd;     // read strobe
    logic [11:0]       addr;   // register offset
    logic [7:0]        wdata;  // write data
  } mnco_bus_t;

endpackage

/* File: tb/testbench.sv */
// self-checking testbench for the paged main oscillator control block
`timescale 1ns/10ps
`default_nettype none
module testbench
  import mnco_pkg::*;
();
  // ==========================================================================
  // clock, reset, stimulus and observed outputs
  logic                        ref_clk   = 1'b0;  // 50 MHz clock
  logic                        rst       = 1'b1;  // async reset, active high
  logic                        sysrefPin = 1'b0;  // sync reference level
  mnco_bus_t                   busReq    = '0;    // one-cycle register access
  logic      [7:0]             rdData;            // read data
  logic                        rdValid;           // read data strobe
  mnco_cfg_t [1:0]             pathCfg;           // per-path configuration
  logic      [1:0][WORD_W-1:0] activeWord;        // word in use per path
  logic      [1:0]             loadStrobe;        // load pulse per path
  logic      [1:0]             ncoResetPulse;     // sync reset pulse per path
  int                          mismatches = 0;    // failed comparisons
  int                          cmpCount   = 0;    // comparisons made
  int                          loadCnt[2] = '{0, 0};  // load pulses seen
  int                          syncCnt[2] = '{0, 0};  // sync pulses seen
  logic      [47:0]            expW;              // expected active word
  logic      [7:0]             rb;                // last read byte

  always #10 ref_clk = ~ref_clk;

  mnco_main_ctrl #(.NUM_PATHS(2)) uut (
    .ref_clk(ref_clk), .rst(rst), .busReq(busReq), .sysrefPin(sysrefPin),
    .rdData(rdData), .rdValid(rdValid), .pathCfg(pathCfg), .activeWord(activeWord),
    .loadStrobe(loadStrobe), .ncoResetPulse(ncoResetPulse));

  // pulses are counted, so a missing or doubled pulse shows up in the counts
  always @(posedge ref_clk) begin
    for (int p = 0; p < 2; p++) begin
      if (loadStrobe[p] === 1'b1) loadCnt[p]++;
      if (ncoResetPulse[p] === 1'b1) syncCnt[p]++;
    end
  end

  // ==========================================================================
  // verdict and comparisons
  task automatic finish_test();
    if (mismatches == 0 && cmpCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
    cmpCount++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_word(input logic [47:0] got, input logic [47:0] exp, input string msg);
    cmpCount++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // ==========================================================================
  // register accesses, entered and left at a falling edge; the idle cycle
  // after each keeps two accesses from touching the strobe in one step
  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    busReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge ref_clk);
    busReq = '0;
    @(negedge ref_clk);
  endtask

  task automatic reg_rd(input logic [11:0] a, input logic [7:0] exp, input string msg);
    int i;
    busReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge ref_clk);
    busReq = '0;
    for (i = 0; i < 3 && rdValid !== 1'b1; i++) @(negedge ref_clk);
    if (i == 3) begin
      mismatches++;
      $display("unexpected at %0t: no read strobe", $time);
      finish_test();
    end
    chk_byte(rdData, exp, msg);
    @(negedge ref_clk);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    chk_byte(8'(pathCfg[1]), 8'h01, "cfg reset");
    reg_rd(ADDR_CFG, 8'h01, "cfg read reset");
    reg_rd(ADDR_UPD, 8'h00, "update reset");
    reg_rd(ADDR_PAGE, 8'h03, "page reset");
    chk_word(activeWord[0], 48'h0, "word reset");
  endtask

  // one path changed, the other must keep its own copy
  task automatic t_paged_cfg();
    reg_wr(ADDR_PAGE, 8'h02);
    reg_wr(ADDR_CFG, 8'hfe);
    chk_byte(8'(pathCfg[1]), 8'h0e, "path1 cfg");
    chk_byte(8'(pathCfg[0]), 8'h01, "path0 untouched");
    reg_rd(ADDR_CFG, 8'h0e, "path1 cfg read");
    reg_wr(ADDR_PAGE, 8'h01);
    reg_rd(ADDR_CFG, 8'h01, "path0 cfg read");
    reg_wr(ADDR_CFG, 8'h08);
    chk_byte(8'(pathCfg[0]), 8'h08, "path0 enable");
    reg_wr(ADDR_PAGE, 8'h03);
  endtask

  task automatic t_reserved();
    reg_wr(ADDR_UPD, 8'h8a);
    reg_rd(ADDR_UPD, 8'h00, "reserved and ack");
    reg_rd(12'h200, 8'h00, "unmapped read");
  endtask

  task automatic t_sw_load();
    int n;
    for (int i = 0; i < WORD_BYTES; i++) reg_wr(ADDR_WORD0 + 12'(i), 8'ha0 + 8'(i));
    expW = 48'ha5a4a3a2a1a0;
    chk_word(activeWord[0], 48'h0, "pending only");
    n = loadCnt[0];
    reg_wr(ADDR_UPD, 8'h01);
    chk_byte(8'(loadCnt[0] - n), 8'h01, "sw load");
    chk_byte(8'(loadCnt[1]), 8'h01, "path1 load");
    chk_word(activeWord[0], expW, "path0 word");
    chk_word(activeWord[1], expW, "path1 word");
    reg_rd(ADDR_UPD, 8'h03, "ack set");
    reg_wr(ADDR_UPD, 8'h01);
    chk_byte(8'(loadCnt[0] - n), 8'h01, "no reload");
    reg_wr(ADDR_UPD, 8'h00);
    reg_rd(ADDR_UPD, 8'h00, "ack cleared");
  endtask

  // auto codes 1..6 must fire after their own byte, then code zero and code seven after none
  task automatic t_auto();
    int n;
    for (int k = 1; k <= 6; k++) begin
      reg_wr(ADDR_UPD, 8'(k << 4));
      n = loadCnt[0];
      reg_wr(ADDR_WORD0 + 12'(k - 1), 8'h30 + 8'(k));
      @(negedge ref_clk);
      expW[8*(k-1) +: 8] = 8'h30 + 8'(k);
      chk_byte(8'(loadCnt[0] - n), 8'h01, "auto load");
      chk_word(activeWord[0], expW, "auto word");
      reg_rd(ADDR_UPD, 8'((k << 4) | 2), "auto ack");
    end
    reg_wr(ADDR_UPD, 8'h00);
    n = loadCnt[0];
    reg_wr(ADDR_WORD0, 8'h5c);
    repeat (3) @(negedge ref_clk);
    chk_byte(8'(loadCnt[0] - n), 8'h00, "mode zero");
    chk_word(activeWord[0], expW, "word held");
    // code seven names no byte, so even the top byte must stay quiet
    reg_wr(ADDR_UPD, 8'h70);
    n = loadCnt[0];
    reg_wr(ADDR_WORD5, 8'h36);
    repeat (3) @(negedge ref_clk);
    chk_byte(8'(loadCnt[0] - n), 8'h00, "code seven");
  endtask

  task automatic t_sync();
    int n;
    int n1;
    int i;
    reg_wr(ADDR_UPD, 8'h04);
    n = syncCnt[0];
    n1 = syncCnt[1];
    sysrefPin = 1'b1;
    for (i = 0; i < 8 && syncCnt[0] == n; i++) @(negedge ref_clk);
    if (i == 8) begin
      mismatches++;
      $display("unexpected at %0t: no sync load", $time);
      finish_test();
    end
    expW[7:0] = 8'h5c;
    chk_word(activeWord[0], expW, "sync word");
    repeat (4) @(negedge ref_clk);
    sysrefPin = 1'b0;
    chk_byte(8'(syncCnt[0] - n), 8'h01, "one sync pulse");
    chk_byte(8'(syncCnt[1] - n1), 8'h01, "path1 sync");
    reg_rd(ADDR_UPD, 8'h06, "sync ack");
  endtask

  // no shift wanted: oscillator stays enabled while the word goes to zero
  task automatic t_zero_word();
    reg_wr(ADDR_CFG, 8'h08);
    for (int i = 0; i < WORD_BYTES; i++) reg_wr(ADDR_WORD0 + 12'(i), 8'h00);
    reg_wr(ADDR_UPD, 8'h01);
    chk_word(activeWord[0], 48'h0, "zero word");
    chk_byte(8'(pathCfg[0]), 8'h08, "still enabled");
  endtask

  // ==========================================================================
  // main sequence: reset for two cycles, then the scenarios
  initial begin
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    t_reset();
    t_paged_cfg();
    t_reserved();
    t_sw_load();
    t_auto();
    t_sync();
    t_zero_word();
    finish_test();
  end
endmodule // testbench
`default_nettype wire
